// file: lpmc_pkg.sv
// package: register map, encodings and state types of the low power controller
package lpmc_pkg;

  // ***************************************************************
  // register offsets (byte addresses, one aligned word each)
  // ***************************************************************
  localparam logic [7:0] OFF_STANDBY_CTRL = 8'h00; // standby_control_reg
  localparam logic [7:0] OFF_POWER_MODE = 8'h04;   // operating power mode
  localparam logic [7:0] OFF_CLK_SEL = 8'h08;      // system clock source
  localparam logic [7:0] OFF_WAKE_EN = 8'h0C;      // interrupt_event_link_select
  localparam logic [7:0] OFF_SNOOZE_CFG = 8'h10;   // snooze request / wake masks
  localparam logic [7:0] OFF_STATUS = 8'h14;       // current state, read only
  localparam logic [7:0] OFF_WAKE_CAUSE = 8'h18;   // last wake cause, read only

  // ***************************************************************
  // field positions and widths
  // ***************************************************************
  localparam int STANDBY_BIT = 0;      // 1 selects software standby
  localparam int NUM_IRQ = 8;          // interrupt source lines
  localparam int SNZ_WAKE_POS = 8;     // snooze wake mask starts here
  localparam int STATUS_CLK_POS = 4;   // clock field in status word
  localparam int STATUS_PWR_POS = 8;   // power mode field in status word
  localparam int CAUSE_RST_POS = 8;    // reset cause bits in cause word

  // ***************************************************************
  // reset values
  // ***************************************************************
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  localparam logic [7:0] RST_WAKE_EN = 8'h00;
  localparam logic [7:0] RST_SNZ_MASK = 8'h00;

  // ***************************************************************
  // enumerations
  // ***************************************************************
  // low power state
  typedef enum logic [1:0] {
    ST_NORMAL,
    ST_SLEEP,
    ST_STANDBY,
    ST_SNOOZE
  } lpmc_state_t;

  // operating power control setting
  typedef enum logic [1:0] {
    PWR_HIGH,
    PWR_MIDDLE,
    PWR_LOW,
    PWR_SUBOSC
  } lpmc_pwr_t;

  // system clock source
  typedef enum logic [1:0] {
    CLK_FAST,
    CLK_MEDIUM,
    CLK_SLOW
  } lpmc_clk_t;

endpackage : lpmc_pkg

// file: lpmc_bus_if.sv
// interface: decoded register access from bus slave to controller core
`timescale 1ns/1ps
`default_nettype none
interface lpmc_bus_if;
  logic wr;          // one-cycle write strobe
  logic [7:0] addr;  // byte address
  logic [31:0] wdata; // write data
  logic [31:0] rdata; // read data for addr, combinational
  modport slave (output wr, output addr, output wdata, input rdata);
  modport core (input wr, input addr, input wdata, output rdata);
endinterface : lpmc_bus_if
`default_nettype wire

// file: lpmc_avalon_slave.sv
// module: avalon-mm slave front end, one wait state on every access
`timescale 1ns/1ps
`default_nettype none
module lpmc_avalon_slave (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // avalon-mm
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // towards the core
  lpmc_bus_if.slave bus
);

  // ***************************************************************
  // state
  // ***************************************************************
  typedef struct packed {
    logic ack;          // answer phase of current access
    logic waitreq;      // registered waitrequest, high out of reset
    logic [31:0] rdata; // captured read data
  } lpmc_slv_t;

  lpmc_slv_t s_q;
  lpmc_slv_t s_d;

  // the request is held by the master, so address and data pass through
  assign bus.addr = avs_address;
  assign bus.wdata = avs_writedata;
  // write takes effect only in the ack cycle, exactly once
  assign bus.wr = avs_write & s_q.ack;
  // waitrequest low only in the ack cycle, so a request lasts two cycles;
  // kept in its own flop so the pin is not a gate behind a register
  assign avs_waitrequest = s_q.waitreq;
  assign avs_readdata = s_q.rdata;

  // next state: ack follows one cycle after request, then drops
  always_comb begin
    s_d = s_q;
    s_d.ack = (avs_read | avs_write) & ~s_q.ack;
    s_d.waitreq = ~s_d.ack;
    if ((avs_read | avs_write) & ~s_q.ack) begin
      s_d.rdata = avs_read ? bus.rdata : lpmc_pkg::RST_WORD;
    end
  end

  // registers
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      s_q <= '0;
      s_q.waitreq <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

endmodule : lpmc_avalon_slave
`default_nettype wire

// file: lpmc_ctrl.sv
// module: low power mode controller top, states, power mode and clock select
// ***************************************************************
// ***************************************************************
// one state register tracks normal, sleep, standby and snooze;
// software reaches the settings through a small avalon-mm slave
// ***************************************************************
`timescale 1ns/1ps
`default_nettype none
module lpmc_ctrl (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // avalon-mm register port
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // cpu core
  input wire logic cpu_wfi,
  output logic cpu_halt,
  output logic cpu_retain,
  // interrupt and reset sources
  input wire logic [7:0] irq_src,
  input wire logic snooze_req,
  input wire logic external_reset_pin,
  input wire logic por_event,
  input wire logic vmon_reset,
  // controls to the rest of the chip
  output logic periph_run,
  output logic snooze_periph_run,
  output logic osc_run,
  output logic io_hold,
  output logic sram_retain,
  output logic [1:0] power_mode,
  output logic [1:0] sys_clk_sel,
  output logic [1:0] lp_state,
  output logic reset_req
);

  // ***************************************************************
  // state
  // ***************************************************************
  typedef struct packed {
    lpmc_pkg::lpmc_state_t st;    // current low power state
    logic standby_sel;            // standby_control_reg select bit
    lpmc_pkg::lpmc_pwr_t pwr;     // operating power control setting
    lpmc_pkg::lpmc_clk_t clk;     // selected system clock source
    logic [7:0] wake_en;          // interrupt_event_link_select mask
    logic [7:0] snz_req_en;       // allows snooze request per source
    logic [7:0] snz_wake_en;      // interrupts that wake from snooze
    logic [10:0] cause;           // last wake cause: irq bits, resets
    // registered outputs
    logic cpu_halt;
    logic cpu_retain;
    logic periph_run;
    logic snooze_periph_run;
    logic osc_run;
    logic io_hold;
    logic sram_retain;
    logic reset_req;
  } lpmc_core_t;

  // one register holds the whole controller core; c_d is its next value,
  // built in full by the single next-state process below
  lpmc_core_t c_q;
  lpmc_core_t c_d;

  // decoded register access between the slave and this core
  lpmc_bus_if bus ();

  // any of the three reset sources, level
  logic any_reset;
  // interrupts linked for wake from sleep or standby
  logic [7:0] wake_hit;
  // interrupts linked for wake from snooze
  logic [7:0] snz_hit;

  // ***************************************************************
  // bus slave
  // ***************************************************************
  lpmc_avalon_slave u_slave (
    .ref_clk(ref_clk),
    .rst(rst),
    .avs_address(avs_address),
    .avs_read(avs_read),
    .avs_write(avs_write),
    .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest),
    .bus(bus.slave)
  );

  // ***************************************************************
  // wake and reset qualification
  // ***************************************************************
  // reset sources are levels; one cycle is enough to force normal
  // state, so no edge detector sits in front of them
  // limitation: a source held high keeps reset_req high for as long as it is held
  assign any_reset = external_reset_pin | por_event | vmon_reset;
  // an unlinked interrupt cannot wake the part from sleep or standby
  assign wake_hit = irq_src & c_q.wake_en;
  assign snz_hit = irq_src & c_q.snz_wake_en;

  // ***************************************************************
  // read mux
  // ***************************************************************
  // unmapped addresses read as zero
  always_comb begin
    bus.rdata = lpmc_pkg::RST_WORD;
    unique case (bus.addr)
      lpmc_pkg::OFF_STANDBY_CTRL: begin
        bus.rdata[lpmc_pkg::STANDBY_BIT] = c_q.standby_sel;
      end
      lpmc_pkg::OFF_POWER_MODE: begin
        bus.rdata[1:0] = c_q.pwr;
      end
      lpmc_pkg::OFF_CLK_SEL: begin
        bus.rdata[1:0] = c_q.clk;
      end
      lpmc_pkg::OFF_WAKE_EN: begin
        bus.rdata[7:0] = c_q.wake_en;
      end
      lpmc_pkg::OFF_SNOOZE_CFG: begin
        bus.rdata[7:0] = c_q.snz_req_en;
        bus.rdata[lpmc_pkg::SNZ_WAKE_POS +: 8] = c_q.snz_wake_en;
      end
      // status is read only; writes to it are dropped
      lpmc_pkg::OFF_STATUS: begin
        bus.rdata[1:0] = c_q.st;
        bus.rdata[lpmc_pkg::STATUS_CLK_POS +: 2] = c_q.clk;
        bus.rdata[lpmc_pkg::STATUS_PWR_POS +: 2] = c_q.pwr;
      end
      // cause holds the last wake reason until the next wake or reset
      lpmc_pkg::OFF_WAKE_CAUSE: begin
        bus.rdata[10:0] = c_q.cause;
      end
      default: begin
        bus.rdata = lpmc_pkg::RST_WORD;
      end
    endcase
  end

  // ***************************************************************
  // next state
  // ***************************************************************
  always_comb begin
    c_d = c_q;
    // reset_req is a pulse: cleared unless a source is seen this cycle
    c_d.reset_req = 1'b0;

    // a write and a state change may land in one cycle; both take
    // effect, except that a reset source overrides mode and clock
    // register writes; the cpu is halted in low power states, so in
    // practice writes only arrive in normal state
    if (bus.wr) begin
      unique case (bus.addr)
        lpmc_pkg::OFF_STANDBY_CTRL: begin
          c_d.standby_sel = bus.wdata[lpmc_pkg::STANDBY_BIT];
        end
        lpmc_pkg::OFF_POWER_MODE: begin
          // power mode not changeable from standby
          if (c_q.st != lpmc_pkg::ST_STANDBY) begin
            c_d.pwr = lpmc_pkg::lpmc_pwr_t'(bus.wdata[1:0]);
          end
        end
        lpmc_pkg::OFF_CLK_SEL: begin
          // reserved code 3 is ignored, old source kept; no reset
          // is taken, settling is left to software
          if (bus.wdata[1:0] != 2'h3) begin
            c_d.clk = lpmc_pkg::lpmc_clk_t'(bus.wdata[1:0]);
          end
        end
        lpmc_pkg::OFF_WAKE_EN: begin
          c_d.wake_en = bus.wdata[7:0];
        end
        lpmc_pkg::OFF_SNOOZE_CFG: begin
          // request mask in the low byte, wake mask in the next byte
          c_d.snz_req_en = bus.wdata[7:0];
          c_d.snz_wake_en = bus.wdata[lpmc_pkg::SNZ_WAKE_POS +: 8];
        end
        default: begin
          // status, wake cause and unmapped words: write dropped
          c_d.reset_req = 1'b0;
        end
      endcase
    end

    // state transitions; reset sources win over everything
    if (any_reset) begin
      c_d.st = lpmc_pkg::ST_NORMAL;
      c_d.reset_req = 1'b1;
      // cause records which reset source ended the state
      c_d.cause = {vmon_reset, por_event, external_reset_pin, 8'h00};
      c_d.pwr = lpmc_pkg::PWR_HIGH;
      c_d.clk = lpmc_pkg::CLK_FAST;
    end else begin
      unique case (c_q.st)
        lpmc_pkg::ST_NORMAL: begin
          if (cpu_wfi) begin
            // target picked by standby_control_reg at the wfi
            c_d.st = c_q.standby_sel ? lpmc_pkg::ST_STANDBY
                                     : lpmc_pkg::ST_SLEEP;
          end
        end
        lpmc_pkg::ST_SLEEP: begin
          // peripherals keep running, so any linked interrupt ends sleep
          if (|wake_hit) begin
            c_d.st = lpmc_pkg::ST_NORMAL;
            c_d.cause = {3'h0, wake_hit};
          end
        end
        lpmc_pkg::ST_STANDBY: begin
          // wake has priority over a snooze request in the same cycle
          if (|wake_hit) begin
            c_d.st = lpmc_pkg::ST_NORMAL;
            c_d.cause = {3'h0, wake_hit};
          end else if (snooze_req && |(irq_src & c_q.snz_req_en)) begin
            c_d.st = lpmc_pkg::ST_SNOOZE;
          end
        end
        lpmc_pkg::ST_SNOOZE: begin
          // only the snooze wake mask counts here, not the link mask
          if (|snz_hit) begin
            c_d.st = lpmc_pkg::ST_NORMAL;
            c_d.cause = {3'h0, snz_hit};
          end
        end
      endcase
    end

    // outputs follow the next state so they line up with lp_state
    c_d.cpu_halt = (c_d.st != lpmc_pkg::ST_NORMAL);
    // cpu registers retained in every state; reset is the only loss
    c_d.cpu_retain = ~any_reset;
    c_d.periph_run = (c_d.st == lpmc_pkg::ST_NORMAL)
                   | (c_d.st == lpmc_pkg::ST_SLEEP);
    // in snooze only the reduced peripheral set runs
    c_d.snooze_periph_run = (c_d.st == lpmc_pkg::ST_SNOOZE);
    // oscillators stay up in snooze for the peripherals working there
    c_d.osc_run = (c_d.st != lpmc_pkg::ST_STANDBY);
    // io and sram are held in standby and in snooze alike
    c_d.io_hold = (c_d.st == lpmc_pkg::ST_STANDBY)
                | (c_d.st == lpmc_pkg::ST_SNOOZE);
    c_d.sram_retain = c_d.io_hold;
  end

  // ***************************************************************
  // registers
  // ***************************************************************
  // synchronous reset; every field is loaded with a constant
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      // normal state, high power mode, fast oscillator; cpu running
      c_q <= '0;
      c_q.st <= lpmc_pkg::ST_NORMAL;
      c_q.pwr <= lpmc_pkg::PWR_HIGH;
      c_q.clk <= lpmc_pkg::CLK_FAST;
      c_q.wake_en <= lpmc_pkg::RST_WAKE_EN;
      c_q.snz_req_en <= lpmc_pkg::RST_SNZ_MASK;
      c_q.snz_wake_en <= lpmc_pkg::RST_SNZ_MASK;
      c_q.cpu_retain <= 1'b1;
      c_q.periph_run <= 1'b1;
      c_q.osc_run <= 1'b1;
    end else begin
      c_q <= c_d;
    end
  end

  // ***************************************************************
  // outputs, all straight from flip-flops
  // ***************************************************************
  // no logic between these fields and the pins
  assign cpu_halt = c_q.cpu_halt;
  assign cpu_retain = c_q.cpu_retain;
  assign periph_run = c_q.periph_run;
  assign snooze_periph_run = c_q.snooze_periph_run;
  assign osc_run = c_q.osc_run;
  assign io_hold = c_q.io_hold;
  assign sram_retain = c_q.sram_retain;
  assign power_mode = c_q.pwr;
  assign sys_clk_sel = c_q.clk;
  assign lp_state = c_q.st;
  assign reset_req = c_q.reset_req;

endmodule : lpmc_ctrl
`default_nettype wire

// file: lpmc_ctrl_checker.sv
// checker: state, output and reset relations of the low power controller
`timescale 1ns/1ps
`default_nettype none
module lpmc_ctrl_checker (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // cpu and event inputs
  input wire logic avs_write,
  input wire logic cpu_wfi,
  input wire logic [7:0] irq_src,
  input wire logic snooze_req,
  input wire logic external_reset_pin,
  input wire logic por_event,
  input wire logic vmon_reset,
  // controller outputs
  input wire logic cpu_halt,
  input wire logic periph_run,
  input wire logic snooze_periph_run,
  input wire logic osc_run,
  input wire logic io_hold,
  input wire logic sram_retain,
  input wire logic [1:0] power_mode,
  input wire logic [1:0] sys_clk_sel,
  input wire logic [1:0] lp_state,
  input wire logic reset_req
);
  // ***************************************************************
  // helpers
  // ***************************************************************
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  logic rs; // any reset source, these override every other event
  assign rs = external_reset_pin | por_event | vmon_reset;
  // wfi taken in normal with no reset competing
  sequence s_wfi; lp_state == 2'h0 && cpu_wfi && !rs; endsequence
  // snooze just left
  sequence s_snz_left; lp_state == 2'h3 ##1 lp_state != 2'h3; endsequence
  // ***************************************************************
  // properties
  // ***************************************************************
  property p_sleep_run;
    lp_state == 2'h1 |-> cpu_halt && periph_run && osc_run && !io_hold;
  endproperty
  a_sleep_run: assert property (p_sleep_run)
    else $error("sleep outputs wrong");
  property p_sleep_hold;
    lp_state == 2'h1 && irq_src == 8'h00 && !rs |=> lp_state == 2'h1;
  endproperty
  a_sleep_hold: assert property (p_sleep_hold)
    else $error("sleep left without cause");
  property p_stby_stop;
    lp_state == 2'h2 |-> cpu_halt && !periph_run && !osc_run;
  endproperty
  a_stby_stop: assert property (p_stby_stop)
    else $error("standby did not stop cpu or oscillators");
  property p_retain; lp_state[1] |-> io_hold && sram_retain; endproperty
  a_retain: assert property (p_retain)
    else $error("retention missing in standby or snooze");
  property p_snz_entry;
    lp_state == 2'h3 && $past(lp_state) != 2'h3
      |-> $past(lp_state) == 2'h2 && $past(snooze_req);
  endproperty
  a_snz_entry: assert property (p_snz_entry)
    else $error("snooze entered from wrong state");
  property p_snz_exit; s_snz_left |-> lp_state == 2'h0; endproperty
  a_snz_exit: assert property (p_snz_exit)
    else $error("snooze left to a state other than normal");
  property p_wfi;
    s_wfi |=> lp_state inside {2'h1, 2'h2} && cpu_halt;
  endproperty
  a_wfi: assert property (p_wfi)
    else $error("wfi did not enter a low power state");
  property p_rst_src;
    rs |=> lp_state == 2'h0 && reset_req && power_mode == 2'h0
      && sys_clk_sel == 2'h0;
  endproperty
  a_rst_src: assert property (p_rst_src)
    else $error("reset source did not return to normal");
  property p_cfg_keep;
    !avs_write && !rs |=> $stable(power_mode) && $stable(sys_clk_sel);
  endproperty
  a_cfg_keep: assert property (p_cfg_keep)
    else $error("power mode or clock changed without a write");
  property p_halt_tie;
    cpu_halt == (lp_state != 2'h0) && snooze_periph_run == (lp_state == 2'h3);
  endproperty
  a_halt_tie: assert property (p_halt_tie)
    else $error("halt or snooze run disagrees with state");
endmodule : lpmc_ctrl_checker
`default_nettype wire

// file: lpmc_partner.sv
// model: cpu core plus interrupt and reset sources facing the controller
`timescale 1ns/1ps
`default_nettype none
module lpmc_partner (
  // clock
  input wire logic ref_clk,
  // cpu core
  input wire logic cpu_halt,
  output logic cpu_wfi,
  // event sources
  output logic [7:0] irq_src,
  output logic snooze_req,
  output logic external_reset_pin,
  output logic por_event,
  output logic vmon_reset
);
  // all sources idle at time zero
  initial begin
    cpu_wfi = 1'b0;
    irq_src = 8'h00;
    snooze_req = 1'b0;
    {vmon_reset, por_event, external_reset_pin} = 3'h0;
  end
  // a halted cpu executes nothing, so no wfi then
  task wfi;
    if (cpu_halt !== 1'b1) cpu_wfi <= 1'b1;
    @(posedge ref_clk);
    cpu_wfi <= 1'b0;
  endtask : wfi
  // one-cycle interrupt, optionally with a snooze request
  task fire(input logic [7:0] m, input logic snz);
    irq_src <= m;
    snooze_req <= snz;
    @(posedge ref_clk);
    irq_src <= 8'h00;
    snooze_req <= 1'b0;
  endtask : fire
  // one-cycle pulse on pin, power-on or monitor reset
  task hit(input logic [2:0] k);
    {vmon_reset, por_event, external_reset_pin} <= k;
    @(posedge ref_clk);
    {vmon_reset, por_event, external_reset_pin} <= 3'h0;
  endtask : hit
endmodule : lpmc_partner
`default_nettype wire

// file: lpmc_ctrl_tb.sv
// testbench: drives registers and events, compares with a state model
`timescale 1ns/1ps
`default_nettype none
module lpmc_ctrl_tb;
  // ***************************************************************
  // signals
  // ***************************************************************
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] avs_address = 8'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, rd;
  logic avs_waitrequest, cpu_wfi, cpu_halt, cpu_retain, snooze_req;
  logic external_reset_pin, por_event, vmon_reset, periph_run, io_hold;
  logic snooze_periph_run, osc_run, sram_retain, reset_req;
  logic [7:0] irq_src, m;
  logic [1:0] power_mode, sys_clk_sel, lp_state;
  int errors = 0;
  int tests_run = 0;
  int seed = 89865;
  int k;
  always #12.5 ref_clk = ~ref_clk;
  lpmc_ctrl u_dut (.ref_clk(ref_clk), .rst(rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .cpu_wfi(cpu_wfi), .cpu_halt(cpu_halt), .cpu_retain(cpu_retain),
    .irq_src(irq_src), .snooze_req(snooze_req), .por_event(por_event),
    .external_reset_pin(external_reset_pin), .vmon_reset(vmon_reset),
    .periph_run(periph_run), .snooze_periph_run(snooze_periph_run),
    .osc_run(osc_run), .io_hold(io_hold), .sram_retain(sram_retain),
    .power_mode(power_mode), .sys_clk_sel(sys_clk_sel),
    .lp_state(lp_state), .reset_req(reset_req));
  lpmc_partner u_part (.ref_clk(ref_clk), .cpu_halt(cpu_halt),
    .cpu_wfi(cpu_wfi), .irq_src(irq_src), .snooze_req(snooze_req),
    .external_reset_pin(external_reset_pin), .por_event(por_event),
    .vmon_reset(vmon_reset));
  // ***************************************************************
  // tasks
  // ***************************************************************
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask : chk
  // avalon access: hold until waitrequest sampled low, then release
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= d;
    @(posedge ref_clk);
    while (avs_waitrequest !== 1'b0 && n < 50) begin
      @(posedge ref_clk);
      n++;
    end
    if (n == 50) errors++;
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge ref_clk);
  endtask : bus
  // model expectations of every state output for state s
  task cs(input int s);
    chk("lp_state", lp_state, s);
    chk("cpu_halt", cpu_halt, s != 0);
    chk("periph_run", periph_run, s < 2);
    chk("osc_run", osc_run, s != 2);
    chk("sram_retain", sram_retain, s >= 2);
    chk("io_hold", io_hold, s >= 2);
    chk("snooze_run", snooze_periph_run, s == 3);
  endtask : cs
  task results;
    $display("comparisons %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : results
  // hang guard: the whole sequence takes under two hundred cycles
  initial begin
    repeat (4000) @(posedge ref_clk);
    errors++;
    $display("watchdog expired");
    results();
  end
  // ***************************************************************
  // main sequence
  // ***************************************************************
  initial begin
    repeat (12) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    cs(0);
    bus(0, lpmc_pkg::OFF_STATUS, 0);
    chk("status", rd, 0);
    bus(0, 8'h1C, 0);
    chk("unmapped", rd, 0);
    $display("test reset done");
    for (int p = 0; p < 4; p++) begin
      bus(1, lpmc_pkg::OFF_POWER_MODE, p);
      chk("power_mode", power_mode, p);
      bus(0, lpmc_pkg::OFF_STATUS, 0);
      chk("status_pwr", rd, p << lpmc_pkg::STATUS_PWR_POS);
    end
    k = 0;
    for (int i = 0; i < 4; i++) begin
      bus(1, lpmc_pkg::OFF_CLK_SEL, (i + 1) % 4);
      if ((i + 1) % 4 != 3) k = (i + 1) % 4;
      // software lets the new oscillator settle before use
      repeat (4) @(posedge ref_clk);
      chk("sys_clk_sel", sys_clk_sel, k);
    end
    $display("test power and clock done");
    m = 8'($random(seed)) | 8'h01;
    bus(1, lpmc_pkg::OFF_WAKE_EN, m);
    bus(1, lpmc_pkg::OFF_STANDBY_CTRL, 0);
    u_part.wfi();
    @(posedge ref_clk);
    cs(1);
    u_part.fire(~m, 1'b0);
    @(posedge ref_clk);
    cs(1);
    u_part.fire(m, 1'b0);
    @(posedge ref_clk);
    cs(0);
    bus(0, lpmc_pkg::OFF_WAKE_CAUSE, 0);
    chk("cause_sleep", rd, m);
    $display("test sleep done");
    bus(1, lpmc_pkg::OFF_WAKE_EN, 8'h01);
    bus(1, lpmc_pkg::OFF_SNOOZE_CFG, 32'h0000_0402);
    bus(1, lpmc_pkg::OFF_STANDBY_CTRL, 1);
    u_part.wfi();
    @(posedge ref_clk);
    cs(2);
    chk("io_hold", io_hold, 1);
    bus(1, lpmc_pkg::OFF_POWER_MODE, 1);
    chk("pwr_in_standby", power_mode, 3);
    u_part.fire(8'h02, 1'b0);
    @(posedge ref_clk);
    cs(2);
    u_part.fire(8'h02, 1'b1);
    @(posedge ref_clk);
    cs(3);
    u_part.fire(8'h04, 1'b0);
    @(posedge ref_clk);
    cs(0);
    bus(0, lpmc_pkg::OFF_WAKE_CAUSE, 0);
    chk("cause_snooze", rd, 8'h04);
    u_part.wfi();
    @(posedge ref_clk);
    cs(2);
    // a linked wake and a snooze request together: the wake wins
    u_part.fire(8'h03, 1'b1);
    @(posedge ref_clk);
    cs(0);
    bus(0, lpmc_pkg::OFF_WAKE_CAUSE, 0);
    chk("cause_standby", rd, 8'h01);
    $display("test standby and snooze done");
    bus(1, lpmc_pkg::OFF_STANDBY_CTRL, 0);
    for (int j = 0; j < 3; j++) begin
      bus(1, lpmc_pkg::OFF_POWER_MODE, 2);
      bus(1, lpmc_pkg::OFF_CLK_SEL, 1);
      u_part.wfi();
      @(posedge ref_clk);
      cs(1);
      u_part.hit(3'(1 << j));
      @(posedge ref_clk);
      cs(0);
      chk("reset_req", reset_req, 1);
      chk("cpu_retain", cpu_retain, 0);
      chk("pwr_forced", power_mode, 0);
      chk("clk_forced", sys_clk_sel, 0);
      bus(0, lpmc_pkg::OFF_WAKE_CAUSE, 0);
      chk("cause_rst", rd, (1 << j) << lpmc_pkg::CAUSE_RST_POS);
    end
    $display("test reset sources done");
    bus(1, lpmc_pkg::OFF_CLK_SEL, 2);
    rst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    cs(0);
    chk("clk_after_rst", sys_clk_sel, 0);
    bus(0, lpmc_pkg::OFF_WAKE_EN, 0);
    chk("link_after_rst", rd, 0);
    $display("test mid-run reset done");
    results();
  end
endmodule : lpmc_ctrl_tb
bind lpmc_ctrl lpmc_ctrl_checker u_chk (.ref_clk(ref_clk), .rst(rst),
  .avs_write(avs_write), .cpu_wfi(cpu_wfi), .irq_src(irq_src),
  .snooze_req(snooze_req), .external_reset_pin(external_reset_pin),
  .por_event(por_event), .vmon_reset(vmon_reset), .cpu_halt(cpu_halt),
  .periph_run(periph_run), .snooze_periph_run(snooze_periph_run),
  .osc_run(osc_run), .io_hold(io_hold), .sram_retain(sram_retain),
  .power_mode(power_mode), .sys_clk_sel(sys_clk_sel),
  .lp_state(lp_state), .reset_req(reset_req));
`default_nettype wire
